// File: rtl/csbd_params.svh
// constants for the chip-select and bus-direction block
`ifndef CSBD_PARAMS_SVH
`define CSBD_PARAMS_SVH
`define CSBD_OFS_RAM_UPPER 8'hEA
`define CSBD_OFS_RAM_LOWER 8'hEB
`define CSBD_OFS_ROM_UPPER 8'hEC
`define CSBD_OFS_SYS_CFG 8'hED
`define CSBD_OFS_PORT1_DIR 8'hE0
`define CSBD_BOUND_RESET 8'hFF
`define CSBD_CFG_RESET 8'h00
`define CSBD_DIR_RESET 8'hFF
`define CSBD_CFG_WMASK 8'h65
`define CSBD_BIT_DAISY 6
`define CSBD_BIT_ROM_DIS 5
`define CSBD_BIT_EMUL 2
`define CSBD_BIT_CT_PINS 0
`define CSBD_A18_POS 6
`endif

// File: rtl/csbd_pkg.sv
// types for the chip-select and bus-direction block
package csbd_pkg;
  typedef enum logic [3:0] {
    CSBD_CYC_IDLE,
    CSBD_CYC_IO_WR_ON,
    CSBD_CYC_IO_RD_ON,
    CSBD_CYC_IO_WR_OFF,
    CSBD_CYC_IO_RD_OFF,
    CSBD_CYC_MEM_WR,
    CSBD_CYC_MEM_RD,
    CSBD_CYC_REFRESH,
    CSBD_CYC_ACK_ON,
    CSBD_CYC_ACK_OFF
  } csbd_cyc_e;
  typedef enum logic [1:0] {
    CSBD_DIR_FLOAT,
    CSBD_DIR_IN,
    CSBD_DIR_OUT
  } csbd_dir_e;
  typedef struct packed {
    logic daisy_ct_first;
    logic rom_disable;
    logic emulator_mode_enable;
    logic ct_pins;
  } csbd_cfg_s;
endpackage : csbd_pkg

// File: rtl/csbd_top.sv
// chip selects, system configuration and data bus direction
//
// Overview of operation
// - rom select low when A19-A12 at or below rom_upper_bound
// - ram select low when A19-A12 within ram lower and upper bounds inclusive
// - if both ranges hit with rom enabled, only rom select is asserted
// - reset loads all three bound registers with all ones
// - decoder takes A18 from the cpu, not from the shared timer pin
// - config bit 5 forces rom select inactive; resets to zero
// - config bit 6 picks daisy order: one means counter-timer first
// - config bit 2 enables emulator mode; resets to zero
// - config bit 0 gives port one pins to counter-timer; resets zero
// - as master, normal mode: drive writes, input off-chip reads, float on-chip reads and acks
// - as master, emulator mode also drives on-chip reads and on-chip acks
// - not master: input on-chip writes and memory reads, drive on-chip reads
// - port one direction writes ignored while pin-sharing bit set
`timescale 1ns/1ns
`default_nettype none
`include "csbd_params.svh"
module csbd_top
  import csbd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [7:0] CPU_ADDR_HI,
  input wire logic MEM_ACCESS,
  input wire logic BUS_MASTER,
  input wire csbd_cyc_e CYCLE_TYPE,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic ROM_SELECT_N,
  output logic RAM_SELECT_N,
  output logic DATA_OE,
  output logic DATA_IE,
  output logic DAISY_CT_FIRST,
  output logic EMULATOR_MODE_ENABLE,
  output logic CT_PINS_ON_PORT_ONE,
  output logic [7:0] PORT_ONE_DIRECTION
);
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [7:0] rom_upper_r, rom_upper_nxt;
  logic [7:0] ram_upper_r, ram_upper_nxt;
  logic [7:0] ram_lower_r, ram_lower_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] pdir_r, pdir_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  csbd_cfg_s cfg;

  assign cfg = '{cfg_r[`CSBD_BIT_DAISY], cfg_r[`CSBD_BIT_ROM_DIS],
                 cfg_r[`CSBD_BIT_EMUL], cfg_r[`CSBD_BIT_CT_PINS]};

  always_comb begin
    rom_upper_nxt = rom_upper_r;
    ram_upper_nxt = ram_upper_r;
    ram_lower_nxt = ram_lower_r;
    cfg_nxt = cfg_r;
    pdir_nxt = pdir_r;
    rdata_nxt = rdata_r;
    if (IO_WR) begin
      case (IO_ADDR)
        `CSBD_OFS_ROM_UPPER: rom_upper_nxt = IO_WDATA;
        `CSBD_OFS_RAM_UPPER: ram_upper_nxt = IO_WDATA;
        `CSBD_OFS_RAM_LOWER: ram_lower_nxt = IO_WDATA;
        // reserved bits are kept at zero even if software slips
        `CSBD_OFS_SYS_CFG: cfg_nxt = IO_WDATA & `CSBD_CFG_WMASK;
        `CSBD_OFS_PORT1_DIR: if (!cfg.ct_pins) pdir_nxt = IO_WDATA;
        default: ;
      endcase
    end
    // read data is registered and holds until the next read
    if (IO_RD) begin
      case (IO_ADDR)
        `CSBD_OFS_ROM_UPPER: rdata_nxt = rom_upper_r;
        `CSBD_OFS_RAM_UPPER: rdata_nxt = ram_upper_r;
        `CSBD_OFS_RAM_LOWER: rdata_nxt = ram_lower_r;
        `CSBD_OFS_SYS_CFG: rdata_nxt = cfg_r;
        `CSBD_OFS_PORT1_DIR: rdata_nxt = pdir_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rom_upper_r <= `CSBD_BOUND_RESET;
      ram_upper_r <= `CSBD_BOUND_RESET;
      ram_lower_r <= `CSBD_BOUND_RESET;
      cfg_r <= `CSBD_CFG_RESET;
      pdir_r <= `CSBD_DIR_RESET;
      rdata_r <= 8'h00;
    end else begin
      rom_upper_r <= rom_upper_nxt;
      ram_upper_r <= ram_upper_nxt;
      ram_lower_r <= ram_lower_nxt;
      cfg_r <= cfg_nxt;
      pdir_r <= pdir_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // chip-select decode
  // ------------------------------------------------------------
  // CPU_ADDR_HI carries the core's own A18, taken ahead of the timer mux
  // selects are gated by MEM_ACCESS so refresh and io cycles never select memory
  logic rom_hit, ram_hit;
  logic rom_sel_n_r, rom_sel_n_nxt, ram_sel_n_r, ram_sel_n_nxt;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb begin
    rom_hit = in_range(CPU_ADDR_HI, 8'h00, rom_upper_r);
    ram_hit = in_range(CPU_ADDR_HI, ram_lower_r, ram_upper_r);
    rom_sel_n_nxt = !(MEM_ACCESS && rom_hit && !cfg.rom_disable);
    // a disabled rom frees its range so ram can be overlaid there
    ram_sel_n_nxt = !(MEM_ACCESS && ram_hit && !(rom_hit && !cfg.rom_disable));
  end

  // ------------------------------------------------------------
  // data bus direction
  // ------------------------------------------------------------
  // direction is registered like the selects so both change on the same edge
  csbd_dir_e dir;
  logic oe_r, oe_nxt, ie_r, ie_nxt;

  always_comb begin
    dir = CSBD_DIR_FLOAT;
    if (BUS_MASTER) begin
      case (CYCLE_TYPE)
        CSBD_CYC_IO_WR_ON, CSBD_CYC_IO_WR_OFF, CSBD_CYC_MEM_WR: dir = CSBD_DIR_OUT;
        CSBD_CYC_IO_RD_OFF, CSBD_CYC_MEM_RD, CSBD_CYC_ACK_OFF: dir = CSBD_DIR_IN;
        CSBD_CYC_IO_RD_ON, CSBD_CYC_ACK_ON: dir = cfg.emulator_mode_enable ? CSBD_DIR_OUT : CSBD_DIR_FLOAT;
        default: dir = CSBD_DIR_FLOAT;
      endcase
    end else begin
      case (CYCLE_TYPE)
        CSBD_CYC_IO_WR_ON, CSBD_CYC_MEM_RD, CSBD_CYC_ACK_OFF: dir = CSBD_DIR_IN;
        CSBD_CYC_IO_RD_ON, CSBD_CYC_ACK_ON: dir = CSBD_DIR_OUT;
        default: dir = CSBD_DIR_FLOAT;
      endcase
    end
    oe_nxt = (dir == CSBD_DIR_OUT);
    ie_nxt = (dir == CSBD_DIR_IN);
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rom_sel_n_r <= 1'b1;
      ram_sel_n_r <= 1'b1;
      oe_r <= 1'b0;
      ie_r <= 1'b0;
    end else begin
      rom_sel_n_r <= rom_sel_n_nxt;
      ram_sel_n_r <= ram_sel_n_nxt;
      oe_r <= oe_nxt;
      ie_r <= ie_nxt;
    end
  end

  assign ROM_SELECT_N = rom_sel_n_r;
  assign RAM_SELECT_N = ram_sel_n_r;
  assign DATA_OE = oe_r;
  assign DATA_IE = ie_r;
  assign IO_RDATA = rdata_r;
  assign DAISY_CT_FIRST = cfg_r[`CSBD_BIT_DAISY];
  assign EMULATOR_MODE_ENABLE = cfg_r[`CSBD_BIT_EMUL];
  assign CT_PINS_ON_PORT_ONE = cfg_r[`CSBD_BIT_CT_PINS];
  assign PORT_ONE_DIRECTION = pdir_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  rom_decode_a: assert property (
    MEM_ACCESS && CPU_ADDR_HI <= rom_upper_r && !cfg.rom_disable |=> !ROM_SELECT_N)
    else $error("rom select missed");
  // a disabled rom hands its range to ram so ram can overlay it
  ram_decode_a: assert property (
    MEM_ACCESS && CPU_ADDR_HI >= ram_lower_r && CPU_ADDR_HI <= ram_upper_r
    && (CPU_ADDR_HI > rom_upper_r || cfg.rom_disable) |=> !RAM_SELECT_N)
    else $error("ram select missed");
  rom_priority_a: assert property (!ROM_SELECT_N |-> RAM_SELECT_N) else $error("both selects low");
  ram_shadow_a: assert property (
    CPU_ADDR_HI <= rom_upper_r && !cfg.rom_disable |=> RAM_SELECT_N)
    else $error("ram select inside live rom range");
  rom_disable_a: assert property (cfg.rom_disable |=> ROM_SELECT_N) else $error("rom select not disabled");
  cfg_reserved_a: assert property ((cfg_r & ~`CSBD_CFG_WMASK) == 8'h00) else $error("reserved bit set");
  master_write_a: assert property (
    BUS_MASTER && CYCLE_TYPE == CSBD_CYC_MEM_WR |=> DATA_OE && !DATA_IE)
    else $error("write not driven");
  master_float_a: assert property (
    BUS_MASTER && !cfg.emulator_mode_enable && CYCLE_TYPE == CSBD_CYC_ACK_ON |=> !DATA_OE && !DATA_IE)
    else $error("on-chip ack not floated");
  emul_read_a: assert property (
    BUS_MASTER && CYCLE_TYPE == CSBD_CYC_IO_RD_ON |=> DATA_OE == $past(cfg.emulator_mode_enable))
    else $error("on-chip read drive wrong");
  slave_dir_a: assert property (
    !BUS_MASTER && CYCLE_TYPE == CSBD_CYC_MEM_WR |=> !DATA_OE && !DATA_IE)
    else $error("slave memory write not floated");
  slave_read_a: assert property (
    !BUS_MASTER && CYCLE_TYPE == CSBD_CYC_IO_RD_ON |=> DATA_OE && !DATA_IE)
    else $error("slave on-chip read not driven");
  dir_lock_a: assert property (cfg.ct_pins |=> $stable(pdir_r)) else $error("direction written while locked");
  bound_reset_a: assert property (
    $rose(RESET_N) |-> rom_upper_r == `CSBD_BOUND_RESET && ram_upper_r == `CSBD_BOUND_RESET
    && ram_lower_r == `CSBD_BOUND_RESET) else $error("bad reset");
  cfg_reset_a: assert property (
    $rose(RESET_N) |-> cfg_r == `CSBD_CFG_RESET) else $error("config not cleared");

  rom_cov: cover property (!ROM_SELECT_N);
  ram_cov: cover property (!RAM_SELECT_N);
  emul_cov: cover property (cfg.emulator_mode_enable && DATA_OE);
  lock_cov: cover property (cfg.ct_pins && IO_WR && IO_ADDR == `CSBD_OFS_PORT1_DIR);
  overlay_cov: cover property (cfg.rom_disable && !RAM_SELECT_N);
endmodule : csbd_top
`default_nettype wire

// File: test/csbd_mem_model.sv
// stand-in for the external rom and ram chips on the data bus
`timescale 1ns/1ns
`default_nettype none
module csbd_mem_model #(
  parameter logic [7:0] ROM_BYTE = 8'hA5,
  parameter logic [7:0] RAM_BYTE = 8'h5A
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rom_select_n,
  input wire logic ram_select_n,
  input wire logic data_ie,
  output logic [7:0] dq
);
  logic [7:0] held_r;
  // chips answer at once; a released bus shows the inverse of its last byte so a float never reads as stale
  assign dq = (data_ie && !rom_select_n) ? ROM_BYTE : (data_ie && !ram_select_n) ? RAM_BYTE : ~held_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) held_r <= 8'h00;
    else held_r <= dq;
  end
endmodule : csbd_mem_model
`default_nettype wire

// File: test/chip_select_and_bus_direction_tb.sv
// self-checking bench for the chip-select and bus-direction block
`timescale 1ns/1ns
`default_nettype none
`include "csbd_params.svh"
module chip_select_and_bus_direction_tb
  import csbd_pkg::*;
;
  logic MCLK = 1'b0, RESET_N = 1'b0, MEM_ACCESS = 1'b0, BUS_MASTER = 1'b0, IO_WR = 1'b0, IO_RD = 1'b0;
  logic [7:0] CPU_ADDR_HI = 8'h00, IO_ADDR = 8'h00, IO_WDATA = 8'h00, IO_RDATA, PORT_ONE_DIRECTION, dq;
  csbd_cyc_e CYCLE_TYPE = CSBD_CYC_IDLE;
  logic ROM_SELECT_N, RAM_SELECT_N, DATA_OE, DATA_IE, DAISY_CT_FIRST, EMULATOR_MODE_ENABLE, CT_PINS_ON_PORT_ONE;
  logic [7:0] rb = 8'hFF, rl = 8'hFF, ru = 8'hFF, cfg = 8'h00, dir = 8'hFF;
  logic [7:0] offs [6] = '{8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hE0, 8'h55};
  logic [7:0] edges [8] = '{8'h00, 8'h2F, 8'h30, 8'h3F, 8'h40, 8'h9F, 8'hA0, 8'hFF};
  logic [15:0] expq [$];
  logic [15:0] e;
  logic [7:0] obs;
  assign obs = {1'b0, ROM_SELECT_N, RAM_SELECT_N, DATA_OE, DATA_IE, DAISY_CT_FIRST, EMULATOR_MODE_ENABLE,
    CT_PINS_ON_PORT_ONE};
  logic [1:0] kind = 2'd0, kq = 2'd0;
  logic [31:0] rs = 32'hFE605EFA;
  int miscompares = 0, check_count = 0;
  csbd_top u_dut (.MCLK, .RESET_N, .CPU_ADDR_HI, .MEM_ACCESS, .BUS_MASTER, .CYCLE_TYPE, .IO_WR, .IO_RD,
    .IO_ADDR, .IO_WDATA, .IO_RDATA, .ROM_SELECT_N, .RAM_SELECT_N, .DATA_OE, .DATA_IE, .DAISY_CT_FIRST,
    .EMULATOR_MODE_ENABLE, .CT_PINS_ON_PORT_ONE, .PORT_ONE_DIRECTION);
  csbd_mem_model u_mem (.mclk(MCLK), .rst_n(RESET_N), .rom_select_n(ROM_SELECT_N),
    .ram_select_n(RAM_SELECT_N), .data_ie(DATA_IE), .dq(dq));
  initial begin
    forever #50 MCLK = ~MCLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // ----------------------------------------
  // register bus driver, model kept alongside
  // ----------------------------------------
  task automatic io(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK);
    IO_WR = wr;
    IO_RD = rd;
    IO_ADDR = a;
    IO_WDATA = d;
    kind = rd ? 2'd1 : 2'd0;
    if (rd) expq.push_back({dir, a == 8'hEA ? ru : a == 8'hEB ? rl : a == 8'hEC ? rb : a == 8'hED ? cfg :
      a == 8'hE0 ? dir : 8'h00});
    if (wr) case (a)
      `CSBD_OFS_RAM_UPPER: ru = d;
      `CSBD_OFS_RAM_LOWER: rl = d;
      `CSBD_OFS_ROM_UPPER: rb = d;
      `CSBD_OFS_SYS_CFG: cfg = d & 8'h65;
      `CSBD_OFS_PORT1_DIR: if (!cfg[0]) dir = d;
      default: ;
    endcase
  endtask : io
  // bus direction tables, two bits per cycle kind: 10 drive, 01 input, 00 float
  task automatic sel(input logic [7:0] a, input logic m, input logic bm, input logic [3:0] c);
    logic [19:0] t;
    logic r;
    @(negedge MCLK);
    IO_WR = 1'b0;
    IO_RD = 1'b0;
    CPU_ADDR_HI = a;
    MEM_ACCESS = m;
    BUS_MASTER = bm;
    CYCLE_TYPE = csbd_cyc_e'(c);
    kind = 2'd2;
    t = !bm ? 20'h61024 : cfg[2] ? 20'h619A8 : 20'h41988;
    r = m && a <= rb && !cfg[5];
    expq.push_back({8'h00, 1'b0, !r, !(m && a >= rl && a <= ru && !r), t[2 * c +: 2], cfg[6], cfg[2], cfg[0]});
  endtask : sel
  always @(posedge MCLK) kq <= kind;
  always @(negedge MCLK) begin
    if (kq == 2'd1) begin
      e = expq.pop_front();
      check("read data", IO_RDATA, e[7:0]);
      check("port direction", PORT_ONE_DIRECTION, e[15:8]);
    end
    if (kq == 2'd2) begin
      e = expq.pop_front();
      check("chip selects", obs & 8'h60, e[7:0] & 8'h60);
      check("direction and config", obs & 8'h1F, e[7:0] & 8'h1F);
      if (!e[6] && e[3]) check("rom data", dq, 8'hA5);
      else if (!e[5] && e[3]) check("ram data", dq, 8'h5A);
    end
  end
  task automatic wrap_up();
    if (expq.size() != 0) miscompares++;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge MCLK);
    RESET_N = 1'b1;
    foreach (offs[i]) io(1'b0, 1'b1, offs[i], 8'h00);
    sel(8'hFF, 1'b1, 1'b1, 4'd6);
    $display("test reset values done");
    // pin sharing on: port one direction writes must be dropped
    io(1'b1, 1'b0, 8'hED, 8'h65);
    io(1'b1, 1'b0, 8'hE0, 8'h12);
    io(1'b1, 1'b0, 8'h55, 8'h77);
    foreach (offs[i]) io(1'b0, 1'b1, offs[i], 8'h00);
    io(1'b1, 1'b0, 8'hED, 8'h00);
    io(1'b1, 1'b0, 8'hE0, 8'h12);
    io(1'b0, 1'b1, 8'hE0, 8'h00);
    $display("test config and port direction done");
    io(1'b1, 1'b0, 8'hEC, 8'h3F);
    io(1'b1, 1'b0, 8'hEB, 8'h30);
    io(1'b1, 1'b0, 8'hEA, 8'h9F);
    for (int i = 0; i < 120; i++) begin
      rs = lfsr(rs);
      if (i % 10 == 0) io(1'b1, 1'b0, 8'hED, rs[15:8] & 8'h65);
      sel(i < 8 ? edges[i] : rs[7:0], rs[16] | (i < 8), rs[17], 4'(i % 10));
    end
    $display("test decode and direction done");
    io(1'b0, 1'b0, 8'h00, 8'h00);
    io(1'b0, 1'b0, 8'h00, 8'h00);
    wrap_up();
  end
endmodule : chip_select_and_bus_direction_tb
`default_nettype wire
